// file: mpc_board_model.sv
/*
 * Board-side model of the multifunction pins: drives control pin levels.
 * Assumes the bench sets levels through drive(); status pins are read back.
 */
`timescale 1ns/1ps
module mpc_board_model #(
   parameter int NPIN = 7
)(
   // clock
   input  wire logic            clk,
   // device side of the pins
   input  wire logic [NPIN-1:0] pinOut,
   input  wire logic [NPIN-1:0] pinOe,
   // wire level seen by the device
   output logic      [NPIN-1:0] pinIn
);
   logic [NPIN-1:0] boardLevel;

   initial boardLevel = '0;

   // board changes its levels only just after an edge
   task automatic drive(input logic [NPIN-1:0] v);
      @(posedge clk);
      boardLevel <= v;
   endtask

   // wire level: the device wins where it drives, else board logic
   assign pinIn = (pinOe & pinOut) | (~pinOe & boardLevel);
endmodule

// file: mpc_pin_map.sv
/*
 * Multifunction pin code map for codes 0x15..0x3b with APB registers.
 * Assumes pins come from board logic (synchronised here), flags from core logic.
 */
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
// What this block does
// R01: a pin whose output-enable bit is zero is a control input using its 7-bit code.
// R02: control pins sharing a function OR their or-type terms first, then AND the rest.
// R03: a lone control pin applies directly under combine 00/10 and inverted under 01/11.
// R04: status codes 0x1c-0x1f show the reference divider-resync flags.
// R05: control codes 0x20-0x23 drive the per-reference forced-fault bits.
// R06: status codes 0x20-0x23 show each reference's faulted flag.
// R07: status codes 0x24-0x27 show each reference's valid flag.
// R08: control codes 0x28-0x2b request early end of validation per reference.
// R09: an early-validation request only acts on a reference that is faulted.
// R10: status codes 0x28-0x2b show a combined reference-active indication.
// R11: status codes 0x30-0x33 show loop 0 phase, frequency, analog lock and calibration.
// R12: status code 0x34 shows loop 0 active as the OR of six bits.
// R13: status codes 0x35-0x37 show loop 0 freerun, holdover and switching.
// R14: status codes 0x38, 0x3a, 0x3b show history available, clamped and slew limited.
// R15: status code 0x39 shows the loop 0 history-updated event flag.
// R16: unassigned control codes do nothing and unassigned status codes drive low.
module mpc_pin_map
#(
   parameter int NPIN = 7
)(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  srst,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   // multifunction pins
   input  wire logic [NPIN-1:0]       pinIn,
   output logic [NPIN-1:0]            pinOut,
   output logic [NPIN-1:0]            pinOe,
   // internal status sources
   input  wire logic [7:0]            resyncLo,
   input  wire logic [7:0]            resyncHi,
   input  wire logic [3:0][7:0]       refStatus,
   input  wire logic [7:0]            loop0Lock,
   input  wire logic [7:0]            loop0Active,
   input  wire logic [7:0]            loop0State,
   input  wire logic [7:0]            loop0Tune,
   input  wire logic [7:0]            loop0Event,
   // internal control destinations
   output logic [3:0]                 forcedFault,
   output logic [3:0]                 validateReq,
   // interrupt
   output logic                       irq
);
   import mpc_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [CFG_W-1:0]    cfg [NPIN];
   logic [NPIN-1:0]     pinMeta;
   logic [NPIN-1:0]     pinSync;
   logic [NPIN-1:0]     statusFlag;
   logic [NUM_CTRL-1:0] ctrlHit;
   logic [NUM_CTRL-1:0] ctrlVal;
   logic [7:0]          irqStat;
   logic [7:0]          irqMask;
   logic [7:0]          irqEvent;
   logic [7:0]          ctrlPrev;
   logic                access;
   logic                wrStrobe;
   logic                mapped;
   logic [31:0]         next_rdata;
   logic [NPIN-1:0]     cfgSel;
   logic                fault0Alone;
   logic                fault0AndKill;

   // ------------------------------------------------------------
   // apb slave, one wait state
   // ------------------------------------------------------------
   assign access   = psel & penable;
   assign wrStrobe = access & pready & pwrite;

   // per-pin word decode
   always_comb begin
      cfgSel = '0;
      for (int i = 0; i < NPIN; i++) begin
         cfgSel[i] = (paddr == PIN_CFG_BASE + 12'(4 * i));
      end
   end

   // read mux; unmapped words read zero and flag an error
   always_comb begin
      next_rdata = 32'h0000_0000;
      mapped     = 1'b1;
      if (|cfgSel) begin
         for (int i = 0; i < NPIN; i++) begin
            if (cfgSel[i]) begin
               next_rdata = {22'h00_0000, cfg[i]};
            end
         end
      end else if (paddr == IRQ_STAT_ADDR) begin
         next_rdata = {24'h00_0000, irqStat};
      end else if (paddr == IRQ_MASK_ADDR) begin
         next_rdata = {24'h00_0000, irqMask};
      end else if (paddr == CTRL_ST_ADDR) begin
         next_rdata = {24'h00_0000, validateReq, forcedFault};
      end else if (paddr == PIN_LVL_ADDR) begin
         next_rdata = {16'h0000, 8'(pinOut), 8'(pinSync)};
      end else begin
         mapped = 1'b0;
      end
   end

   // answer one cycle after the access phase opens
   always_ff @(posedge clk) begin
      if (srst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= access & ~pready;
         pslverr <= access & ~pready & ~mapped;
         if (access & ~pready & ~pwrite) begin
            prdata <= next_rdata;
         end
      end
   end

   // pin function words
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < NPIN; i++) begin
            cfg[i] <= CFG_RESET;
         end
      end else begin
         for (int i = 0; i < NPIN; i++) begin
            if (wrStrobe && cfgSel[i]) begin
               cfg[i] <= pwdata[CFG_W-1:0];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // pin input synchroniser
   // ------------------------------------------------------------
   // board logic is asynchronous to the core clock
   always_ff @(posedge clk) begin
      if (srst) begin
         pinMeta <= '0;
         pinSync <= '0;
      end else begin
         pinMeta <= pinIn;
         pinSync <= pinMeta;
      end
   end

   // ------------------------------------------------------------
   // control combine, one network per control function
   // ------------------------------------------------------------
   for (genvar f = 0; f < NUM_CTRL; f++) begin : g_ctrl
      localparam logic [6:0] FCODE = (f < 4) ? CODE_FAULT + 7'(f) : CODE_TIMEOUT + 7'(f - 4);
      logic orSeen;
      logic orTerm;
      logic andTerm;
      logic lvl;
      // R02 or-group first, then and-group
      always_comb begin
         orSeen     = 1'b0;
         orTerm     = 1'b0;
         andTerm    = 1'b1;
         lvl        = 1'b0;
         ctrlHit[f] = 1'b0;
         for (int i = 0; i < NPIN; i++) begin
            // R01 oe low means control input
            if (!cfg[i][CFG_OE_BIT] && cfg[i][CFG_CODE_MSB:0] == FCODE) begin
               // R03 combine bit 0 inverts
               lvl        = pinSync[i] ^ cfg[i][CFG_INV_BIT];
               ctrlHit[f] = 1'b1;
               if (cfg[i][CFG_OR_BIT]) begin
                  orSeen = 1'b1;
                  orTerm = orTerm | lvl;
               end else begin
                  andTerm = andTerm & lvl;
               end
            end
         end
         // R16 no assigned pin leaves the bit clear
         ctrlVal[f] = ctrlHit[f] & andTerm & (orTerm | ~orSeen);
      end
   end

   // R05 forced fault and R08 early validation, gated by R09
   always_ff @(posedge clk) begin
      if (srst) begin
         forcedFault <= 4'h0;
         validateReq <= 4'h0;
      end else begin
         forcedFault <= ctrlVal[3:0];
         for (int r = 0; r < 4; r++) begin
            validateReq[r] <= ctrlVal[4 + r] & refStatus[r][FAULTED_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // status pin drivers
   // ------------------------------------------------------------
   for (genvar p = 0; p < NPIN; p++) begin : g_stat
      mpc_status_sel u_sel (
         .code        (cfg[p][CFG_CODE_MSB:0]),
         .resyncLo    (resyncLo),
         .resyncHi    (resyncHi),
         .refStatus   (refStatus),
         .loop0Lock   (loop0Lock),
         .loop0Active (loop0Active),
         .loop0State  (loop0State),
         .loop0Tune   (loop0Tune),
         .loop0Event  (loop0Event),
         .flag        (statusFlag[p])
      );
   end

   // R01 pin drives only with oe set; register keeps the pad glitch free
   always_ff @(posedge clk) begin
      if (srst) begin
         pinOut <= '0;
         pinOe  <= '0;
      end else begin
         for (int i = 0; i < NPIN; i++) begin
            pinOe[i]  <= cfg[i][CFG_OE_BIT];
            pinOut[i] <= cfg[i][CFG_OE_BIT] & statusFlag[i];
         end
      end
   end

   // ------------------------------------------------------------
   // interrupts: rising edges of the control outputs
   // ------------------------------------------------------------
   assign irqEvent = {validateReq, forcedFault} & ~ctrlPrev;

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrlPrev <= IRQ_RESET;
         irqStat  <= IRQ_RESET;
         irqMask  <= IRQ_RESET;
         irq      <= 1'b0;
      end else begin
         ctrlPrev <= {validateReq, forcedFault};
         if (wrStrobe && paddr == IRQ_STAT_ADDR) begin
            irqStat <= (irqStat & ~pwdata[7:0]) | irqEvent;
         end else begin
            irqStat <= irqStat | irqEvent;
         end
         if (wrStrobe && paddr == IRQ_MASK_ADDR) begin
            irqMask <= pwdata[7:0];
         end
         irq <= |(irqStat & irqMask);
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   // helpers: pin 0 the only pin on fault 0, or an and-type pin holding it off
   always_comb begin
      fault0Alone   = !cfg[0][CFG_OE_BIT] && cfg[0][CFG_CODE_MSB:0] == CODE_FAULT;
      fault0AndKill = 1'b0;
      for (int i = 0; i < NPIN; i++) begin
         if (!cfg[i][CFG_OE_BIT] && cfg[i][CFG_CODE_MSB:0] == CODE_FAULT) begin
            if (i != 0) begin
               fault0Alone = 1'b0;
            end
            if (!cfg[i][CFG_OR_BIT] && !(pinSync[i] ^ cfg[i][CFG_INV_BIT])) begin
               fault0AndKill = 1'b1;
            end
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_stat_cfg(logic [6:0] c);
      cfg[0][CFG_OE_BIT] && cfg[0][CFG_CODE_MSB:0] == c;
   endsequence

   property p_ctrl_oe;
      !cfg[0][CFG_OE_BIT] |=> !pinOe[0] && !pinOut[0];
   endproperty
   a_ctrl_oe: assert property (p_ctrl_oe) else $error("control pin drives"); // R01

   property p_and_kill;
      fault0AndKill |=> !forcedFault[0];
   endproperty
   a_and_kill: assert property (p_and_kill) else $error("and term ignored"); // R02

   property p_alone;
      fault0Alone |=> forcedFault[0] == ($past(pinSync[0]) ^ $past(cfg[0][CFG_INV_BIT]));
   endproperty
   a_alone: assert property (p_alone) else $error("lone pin level wrong"); // R03

   property p_resync;
      s_stat_cfg(CODE_RESYNC_AA) |=> pinOut[0] == $past(resyncLo[RESYNC_HI_BIT]);
   endproperty
   a_resync: assert property (p_resync) else $error("resync flag wrong"); // R04

   property p_faulted;
      s_stat_cfg(CODE_FAULTED + 7'h02) |=> pinOut[0] == $past(refStatus[2][FAULTED_BIT]);
   endproperty
   a_faulted: assert property (p_faulted) else $error("faulted flag wrong"); // R06

   property p_valid;
      s_stat_cfg(CODE_VALID + 7'h03) |=> pinOut[0] == $past(refStatus[3][VALID_BIT]);
   endproperty
   a_valid: assert property (p_valid) else $error("valid flag wrong"); // R07

   property p_early;
      validateReq[1] |-> $past(refStatus[1][FAULTED_BIT]);
   endproperty
   a_early: assert property (p_early) else $error("validated a healthy input"); // R09

   property p_loop_act;
      s_stat_cfg(CODE_LOOP_ACT) |=> pinOut[0] == $past(|loop0Active[LOOP_ACT_MSB:0]);
   endproperty
   a_loop_act: assert property (p_loop_act) else $error("loop active wrong"); // R12

   property p_tw_upd;
      s_stat_cfg(CODE_TW_UPD) |=> pinOut[0] == $past(loop0Event[TW_UPD_BIT]);
   endproperty
   a_tw_upd: assert property (p_tw_upd) else $error("history event wrong"); // R15

   property p_unused;
      s_stat_cfg(CODE_UNUSED) ##1 s_stat_cfg(CODE_UNUSED) |=> !pinOut[0];
   endproperty
   a_unused: assert property (p_unused) else $error("unassigned pin not low"); // R16

endmodule

// file: mpc_pkg.sv
/*
 * Shared constants for the multifunction pin code map, codes 0x15..0x3b.
 * Assumes one core clock domain and an APB master with 32-bit data.
 */
package mpc_pkg;

   // ------------------------------------------------------------
   // apb register map
   // ------------------------------------------------------------
   localparam logic [11:0] PIN_CFG_BASE  = 12'h000; // one word per pin, stride 4
   localparam logic [11:0] IRQ_STAT_ADDR = 12'h040;
   localparam logic [11:0] IRQ_MASK_ADDR = 12'h044;
   localparam logic [11:0] CTRL_ST_ADDR  = 12'h048;
   localparam logic [11:0] PIN_LVL_ADDR  = 12'h04c;

   // ------------------------------------------------------------
   // pin function word layout
   // ------------------------------------------------------------
   localparam int          CFG_W        = 10;
   localparam int          CFG_CODE_MSB = 6;
   localparam int          CFG_OE_BIT   = 7;
   localparam int          CFG_OR_BIT   = 9;    // combine code bit 1: or-type
   localparam int          CFG_INV_BIT  = 8;    // combine code bit 0: inverted
   localparam logic [9:0]  CFG_RESET    = 10'h000;
   localparam logic [7:0]  IRQ_RESET    = 8'h00;

   // ------------------------------------------------------------
   // control codes
   // ------------------------------------------------------------
   localparam logic [6:0]  CODE_FAULT    = 7'h20; // 0x20..0x23
   localparam logic [6:0]  CODE_TIMEOUT  = 7'h28; // 0x28..0x2b
   localparam int          NUM_CTRL      = 8;

   // ------------------------------------------------------------
   // status codes
   // ------------------------------------------------------------
   localparam logic [6:0]  CODE_RESYNC_A  = 7'h1c;
   localparam logic [6:0]  CODE_RESYNC_AA = 7'h1d;
   localparam logic [6:0]  CODE_RESYNC_B  = 7'h1e;
   localparam logic [6:0]  CODE_RESYNC_BB = 7'h1f;
   localparam logic [6:0]  CODE_FAULTED   = 7'h20; // 0x20..0x23
   localparam logic [6:0]  CODE_VALID     = 7'h24; // 0x24..0x27
   localparam logic [6:0]  CODE_ACTIVE    = 7'h28; // 0x28..0x2b
   localparam logic [6:0]  CODE_LOCK      = 7'h30; // 0x30..0x33
   localparam logic [6:0]  CODE_LOOP_ACT  = 7'h34;
   localparam logic [6:0]  CODE_STATE     = 7'h35; // 0x35..0x37
   localparam logic [6:0]  CODE_TW_AVAIL  = 7'h38;
   localparam logic [6:0]  CODE_TW_UPD    = 7'h39;
   localparam logic [6:0]  CODE_CLAMP     = 7'h3a;
   localparam logic [6:0]  CODE_SLEW      = 7'h3b;
   localparam logic [6:0]  CODE_UNUSED    = 7'h15;

   // ------------------------------------------------------------
   // source bit positions
   // ------------------------------------------------------------
   localparam int RESYNC_LO_BIT = 3;
   localparam int RESYNC_HI_BIT = 7;
   localparam int FAULTED_BIT   = 3;
   localparam int VALID_BIT     = 4;
   localparam int TW_UPD_BIT    = 2;
   localparam int LOOP_ACT_MSB  = 5;

endpackage

// file: mpc_status_sel.sv
/*
 * Status selector: maps one 7-bit function code to one status flag.
 * Assumes all source flags are on the core clock; output is combinational.
 */
`timescale 1ns/1ps
module mpc_status_sel
(
   // selected code
   input  wire logic [6:0]      code,
   // reference input flags
   input  wire logic [7:0]      resyncLo,
   input  wire logic [7:0]      resyncHi,
   input  wire logic [3:0][7:0] refStatus,
   // digital_loop_0 flags
   input  wire logic [7:0]      loop0Lock,
   input  wire logic [7:0]      loop0Active,
   input  wire logic [7:0]      loop0State,
   input  wire logic [7:0]      loop0Tune,
   input  wire logic [7:0]      loop0Event,
   // chosen flag
   output logic                 flag
);
   import mpc_pkg::*;

   logic [1:0] sub;

   // low two code bits pick the reference input or the flag within a group
   assign sub = code[1:0];

   // one code, one flag; anything unlisted reads low
   always_comb begin
      flag = 1'b0;
      case (code)
         // R04 resync flags
         CODE_RESYNC_A:  flag = resyncLo[RESYNC_LO_BIT];
         CODE_RESYNC_AA: flag = resyncLo[RESYNC_HI_BIT];
         CODE_RESYNC_B:  flag = resyncHi[RESYNC_LO_BIT];
         CODE_RESYNC_BB: flag = resyncHi[RESYNC_HI_BIT];
         // R06 faulted flags
         CODE_FAULTED, CODE_FAULTED + 7'h01, CODE_FAULTED + 7'h02, CODE_FAULTED + 7'h03: begin
            flag = refStatus[sub][FAULTED_BIT];
         end
         // R07 valid flags
         CODE_VALID, CODE_VALID + 7'h01, CODE_VALID + 7'h02, CODE_VALID + 7'h03: begin
            flag = refStatus[sub][VALID_BIT];
         end
         // R10 active: valid and not faulted
         CODE_ACTIVE, CODE_ACTIVE + 7'h01, CODE_ACTIVE + 7'h02, CODE_ACTIVE + 7'h03: begin
            flag = refStatus[sub][VALID_BIT] & ~refStatus[sub][FAULTED_BIT];
         end
         // R11 lock and calibration flags, bits 1 to 4
         CODE_LOCK, CODE_LOCK + 7'h01, CODE_LOCK + 7'h02, CODE_LOCK + 7'h03: begin
            flag = loop0Lock[3'({1'b0, sub}) + 3'd1];
         end
         // R12 loop active
         CODE_LOOP_ACT: flag = |loop0Active[LOOP_ACT_MSB:0];
         // R13 freerun, holdover, switching
         CODE_STATE, CODE_STATE + 7'h01, CODE_STATE + 7'h02: begin
            flag = loop0State[sub - 2'd1];
         end
         // R14 tuning-word history, clamp, slew
         CODE_TW_AVAIL: flag = loop0Tune[0];
         CODE_CLAMP:    flag = loop0Tune[1];
         CODE_SLEW:     flag = loop0Tune[2];
         // R15 history-updated event
         CODE_TW_UPD:   flag = loop0Event[TW_UPD_BIT];
         // R16 unassigned status stays low
         default:       flag = 1'b0;
      endcase
   end

endmodule

// file: testbench.sv
/*
 * Self-checking bench for the pin code map: apb setup, status and control paths.
 * Assumes mpc_pkg, mpc_pin_map and mpc_board_model are compiled first.
 */
`timescale 1ns/1ps
module testbench;
   import mpc_pkg::*;
   localparam int NP = 7;
   logic          clk, srst, psel, penable, pwrite, pready, pslverr, irq, errv;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rdv;
   logic [NP-1:0] pinIn, pinOut, pinOe;
   logic [87:0]   src;
   logic [3:0]    forcedFault, validateReq;
   int            failures, checks_done, c, r, k, lo, n, v;

   // ------------------------------------------------------------
   // clock, reset and the two parties
   // ------------------------------------------------------------
   always #25 clk = ~clk;

   mpc_pin_map #(.NPIN(NP)) u_mpc_pin_map (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .resyncLo(src[7:0]), .resyncHi(src[15:8]), .refStatus(src[47:16]),
      .loop0Lock(src[55:48]), .loop0Active(src[63:56]), .loop0State(src[71:64]),
      .loop0Tune(src[79:72]), .loop0Event(src[87:80]), .forcedFault(forcedFault),
      .validateReq(validateReq), .irq(irq));

   mpc_board_model #(.NPIN(NP)) u_mpc_board_model (.clk(clk), .pinOut(pinOut),
      .pinOe(pinOe), .pinIn(pinIn));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int i;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (i == 20) begin
         failures++;
         $display("CHECK FAILED apb pready expected 1 seen 0");
         stop_test();
      end
   endtask

   task automatic cfg(input int p, input logic [9:0] w);
      apb(1'b1, PIN_CFG_BASE + 12'(4 * p), {22'h0, w});
   endtask

   // sources change just after an edge; status lands one edge later
   task automatic setSrc(input logic [87:0] s);
      @(posedge clk);
      src <= s;
      repeat (3) @(posedge clk);
   endtask

   // control path needs two sync flops plus one register
   task automatic pins(input logic [NP-1:0] p);
      u_mpc_board_model.drive(p);
      repeat (4) @(posedge clk);
   endtask

   // lowest source bit behind a status code, -1 when the code has no source or is one of 0x28-0x2b
   function automatic int srcLo(input logic [6:0] cd);
      if (cd >= 7'h1c && cd <= 7'h1f) return 3 + 4 * int'(cd - 7'h1c);
      if (cd >= 7'h20 && cd <= 7'h23) return 19 + 8 * int'(cd - 7'h20);
      if (cd >= 7'h24 && cd <= 7'h27) return 20 + 8 * int'(cd - 7'h24);
      if (cd >= 7'h30 && cd <= 7'h33) return 49 + int'(cd - 7'h30);
      if (cd == 7'h34) return 56;
      if (cd >= 7'h35 && cd <= 7'h37) return 64 + int'(cd - 7'h35);
      if (cd == 7'h38) return 72;
      if (cd == 7'h39) return 82;
      if (cd == 7'h3a) return 73;
      if (cd == 7'h3b) return 74;
      return -1;
   endfunction

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 0; srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
      src = '0; failures = 0; checks_done = 0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      // reset state and the unmapped word
      apb(1'b0, PIN_CFG_BASE, 32'h0); chk("cfg reset", 32'h0, rdv);
      apb(1'b0, IRQ_MASK_ADDR, 32'h0); chk("mask reset", 32'h0, rdv);
      chk("outputs reset", 32'h0, {forcedFault, validateReq, pinOe});
      apb(1'b0, 12'h0fc, 32'h0); chk("unmapped", 32'h1, {rdv[30:0], errv});
      $display("test reset done");
      // every status code of the range but 0x28-0x2b on pin 0, pin 1 left a control pin
      for (c = 'h15; c <= 'h3b; c++) begin
         if (c >= 'h28 && c <= 'h2b) continue;
         cfg(0, 10'h080 | 10'(c));
         lo = srcLo(7'(c));
         n = (c == 'h34) ? 6 : 1;
         if (lo < 0) begin
            setSrc('1); chk("unassigned status", 0, pinOut[0]);
         end else begin
            for (k = 0; k < n; k++) begin
               setSrc(88'h1 << (lo + k));
               chk("status bit", 1, pinOut[0]);
            end
            setSrc(~(((88'h1 << n) - 1) << lo));
            chk("status rest", 0, pinOut[0]);
         end
         chk("status oe", 2'b01, pinOe[1:0]);
      end
      // active: valid and not faulted
      for (r = 0; r < 4; r++) begin
         cfg(0, 10'h0a8 + 10'(r));
         setSrc(88'h1 << (20 + 8 * r)); chk("active", 1, pinOut[0]);
         setSrc(88'h3 << (19 + 8 * r)); chk("active faulted", 0, pinOut[0]);
      end
      setSrc('0);
      cfg(0, 10'h000);
      $display("test status done");
      // forced-fault codes on pin 5, one reference at a time
      for (r = 0; r < 4; r++) begin
         cfg(5, 10'h020 + 10'(r));
         pins(7'h20); chk("forced fault", 32'h1 << r, forcedFault);
         pins(7'h00); chk("forced fault off", 0, forcedFault);
      end
      cfg(5, 10'h024);
      pins(7'h20); chk("unassigned control", 0, {forcedFault, validateReq});
      cfg(5, 10'h000);
      // lone pin 0 under each combine code
      for (k = 0; k < 8; k++) begin
         cfg(0, {2'(k >> 1), 8'h20});
         pins(7'(k & 1));
         chk("lone pin", (k & 1) ^ ((k >> 1) & 1), forcedFault[0]);
      end
      cfg(0, 10'h000);
      // pins 0..3 on one function: and, not or, not and, or
      cfg(0, 10'h021); cfg(1, 10'h321); cfg(2, 10'h121); cfg(3, 10'h221);
      for (v = 0; v < 16; v++) begin
         pins(7'(v));
         chk("combined", (!v[1] || v[3]) && v[0] && !v[2], forcedFault[1]);
      end
      for (k = 0; k < 4; k++) cfg(k, 10'h000);
      pins(7'h00);
      $display("test control done");
      // early validation on pin 6 needs the faulted flag
      for (r = 0; r < 4; r++) begin
         cfg(6, 10'h028 + 10'(r));
         pins(7'h40); chk("validate idle", 0, validateReq);
         setSrc(88'h1 << (19 + 8 * r)); chk("validate", 32'h1 << r, validateReq);
         apb(1'b0, CTRL_ST_ADDR, 32'h0); chk("ctrl state", 32'h10 << r, rdv);
         pins(7'h00);
         setSrc('0);
      end
      $display("test validate done");
      // sticky events, mask, clear by writing ones
      apb(1'b0, IRQ_STAT_ADDR, 32'h0); chk("irq status", 32'hff, rdv);
      chk("irq masked", 0, irq);
      apb(1'b1, IRQ_MASK_ADDR, 32'h10);
      repeat (3) @(posedge clk);
      chk("irq raised", 1, irq);
      apb(1'b1, IRQ_STAT_ADDR, 32'h10);
      repeat (3) @(posedge clk);
      chk("irq cleared", 0, irq);
      apb(1'b0, IRQ_STAT_ADDR, 32'h0); chk("irq status left", 32'hef, rdv);
      $display("test irq done");
      stop_test();
   end
endmodule
